/* File: odl_branch_target.sv */
`timescale 1ns/1ps
module odl_branch_target
	import odl_pkg::*;
(
	input wire logic [15:0] next_ip,
	input wire logic [7:0] disp_low,
	input wire logic [7:0] disp_high,
	input wire logic short_form,
	output logic [15:0] target
);

	logic [15:0] disp;

	// Short forms carry a signed byte, so it is sign extended before the add.
	assign disp = short_form ? {{8{disp_low[7]}}, disp_low} : {disp_high, disp_low}; // [RULE_26]
	assign target = next_ip + disp; // [RULE_26]

endmodule : odl_branch_target

/* File: odl_classifier.sv */
`timescale 1ns/1ps
module odl_classifier
	import odl_pkg::*;
(
	input wire logic [7:0] opc,
	input wire logic [7:0] modrm,
	output odl_class_t cls
);

	function automatic odl_class_t mk(input odl_op_t op, input logic m, input logic [2:0] l);
		return '{op: op, has_modrm: m, imm_len: l};
	endfunction : mk

	logic [2:0] imm_w;
	assign imm_w = opc[W_BIT] ? LEN_WORD : LEN_BYTE;

	always_comb begin
		cls = mk(OP_NONE, 1'b0, LEN_NONE);
		unique case (opc)
			OPC_BR_NEAR: cls = mk(OP_BRANCH_NEAR, 1'b0, LEN_WORD); // [RULE_07]
			OPC_BR_SHORT: cls = mk(OP_BRANCH_SHORT, 1'b0, LEN_BYTE); // [RULE_07]
			OPC_BR_FAR: cls = mk(OP_BRANCH_FAR, 1'b0, LEN_FAR); // [RULE_07]
			OPC_EXIT_NEAR: cls = mk(OP_EXIT_NEAR, 1'b0, LEN_NONE); // [RULE_08]
			OPC_EXIT_NEAR_IMM: cls = mk(OP_EXIT_NEAR_IMM, 1'b0, LEN_WORD); // [RULE_08]
			OPC_EXIT_FAR: cls = mk(OP_EXIT_FAR, 1'b0, LEN_NONE); // [RULE_08]
			OPC_EXIT_FAR_IMM: cls = mk(OP_EXIT_FAR_IMM, 1'b0, LEN_WORD); // [RULE_08]
			OPC_BR_LESS: cls = mk(OP_BRANCH_IF_LESS, 1'b0, LEN_BYTE); // [RULE_09]
			OPC_BR_LESS_EQUAL: cls = mk(OP_BRANCH_IF_LESS_EQUAL, 1'b0, LEN_BYTE); // [RULE_09]
			OPC_BR_GREATER: cls = mk(OP_BRANCH_IF_GREATER, 1'b0, LEN_BYTE); // [RULE_09]
			OPC_BR_BELOW: cls = mk(OP_BRANCH_IF_BELOW, 1'b0, LEN_BYTE); // [RULE_10]
			OPC_BR_BELOW_EQUAL: cls = mk(OP_BRANCH_IF_BELOW_EQUAL, 1'b0, LEN_BYTE); // [RULE_10]
			OPC_BR_ABOVE: cls = mk(OP_BRANCH_IF_ABOVE, 1'b0, LEN_BYTE); // [RULE_10]
			OPC_BR_EQUAL: cls = mk(OP_BRANCH_IF_EQUAL, 1'b0, LEN_BYTE); // [RULE_11]
			OPC_BR_NOT_EQUAL: cls = mk(OP_BRANCH_IF_NOT_EQUAL, 1'b0, LEN_BYTE); // [RULE_11]
			OPC_BR_OVERFLOW: cls = mk(OP_BRANCH_IF_OVERFLOW, 1'b0, LEN_BYTE); // [RULE_11]
			OPC_BR_PARITY_EVEN: cls = mk(OP_BRANCH_IF_PARITY_EVEN, 1'b0, LEN_BYTE); // [RULE_12]
			OPC_BR_PARITY_ODD: cls = mk(OP_BRANCH_IF_PARITY_ODD, 1'b0, LEN_BYTE); // [RULE_12]
			OPC_BR_NEGATIVE: cls = mk(OP_BRANCH_IF_NEGATIVE, 1'b0, LEN_BYTE); // [RULE_12]
			OPC_COUNTED: cls = mk(OP_COUNTED_BRANCH, 1'b0, LEN_BYTE); // [RULE_13]
			OPC_COUNTED_ZERO: cls = mk(OP_COUNTED_BRANCH_WHILE_ZERO, 1'b0, LEN_BYTE); // [RULE_14]
			OPC_COUNTED_NONZERO: begin // [RULE_14]
				cls = mk(OP_COUNTED_BRANCH_WHILE_NONZERO, 1'b0, LEN_BYTE);
			end
			OPC_BR_COUNTER_ZERO: cls = mk(OP_BRANCH_IF_COUNTER_ZERO, 1'b0, LEN_BYTE); // [RULE_15]
			OPC_TRAP_TYPE: cls = mk(OP_TRAP_TYPE, 1'b0, LEN_BYTE); // [RULE_16]
			OPC_TRAP_BREAK: cls = mk(OP_TRAP_BREAK, 1'b0, LEN_NONE); // [RULE_16]
			OPC_TRAP_OVERFLOW: cls = mk(OP_TRAP_OVERFLOW, 1'b0, LEN_NONE); // [RULE_16]
			OPC_TRAP_EXIT: cls = mk(OP_TRAP_EXIT, 1'b0, LEN_NONE); // [RULE_17]
			OPC_CARRY_CLEAR: cls = mk(OP_CARRY_CLEAR, 1'b0, LEN_NONE); // [RULE_18]
			OPC_CARRY_INVERT: cls = mk(OP_CARRY_INVERT, 1'b0, LEN_NONE); // [RULE_18]
			OPC_CARRY_SET: cls = mk(OP_CARRY_SET, 1'b0, LEN_NONE); // [RULE_18]
			OPC_DIRECTION_CLEAR: cls = mk(OP_DIRECTION_CLEAR, 1'b0, LEN_NONE); // [RULE_19]
			OPC_DIRECTION_SET: cls = mk(OP_DIRECTION_SET, 1'b0, LEN_NONE); // [RULE_19]
			OPC_IRQ_ENABLE_CLEAR: cls = mk(OP_IRQ_ENABLE_CLEAR, 1'b0, LEN_NONE); // [RULE_20]
			OPC_IRQ_ENABLE_SET: cls = mk(OP_IRQ_ENABLE_SET, 1'b0, LEN_NONE); // [RULE_20]
			OPC_PROCESSOR_STOP: cls = mk(OP_PROCESSOR_STOP, 1'b0, LEN_NONE); // [RULE_21]
			OPC_COPROC_WAIT: cls = mk(OP_COPROC_WAIT, 1'b0, LEN_NONE); // [RULE_21]
			default: begin
				if ((opc & OPC_SHIFT_MSK) == OPC_SHIFT) begin // [RULE_01]
					cls.has_modrm = 1'b1;
					if (f_reg(modrm) == REG_ROTATE_CARRY_RIGHT) begin
						cls.op = OP_ROTATE_RIGHT_THROUGH_CARRY;
					end
				end else if ((opc & OPC_W_MSK) == OPC_FLAG_AND_IMM) begin // [RULE_02]
					cls.has_modrm = 1'b1;
					if (f_reg(modrm) == REG_FLAG_AND_IMM) begin
						cls = mk(OP_FLAG_AND_IMM, 1'b1, imm_w);
					end
				end else if ((opc & OPC_W_MSK) == OPC_FLAG_AND_RM) begin // [RULE_03]
					cls = mk(OP_FLAG_AND_RM, 1'b1, LEN_NONE);
				end else if ((opc & OPC_DW_MSK) == OPC_OR_RM) begin // [RULE_04]
					cls = mk(OP_OR_RM, 1'b1, LEN_NONE);
				end else if ((opc & OPC_DW_MSK) == OPC_XOR_RM) begin // [RULE_04]
					cls = mk(OP_XOR_RM, 1'b1, LEN_NONE);
				end else if ((opc & OPC_W_MSK) == OPC_STR_COPY) begin // [RULE_05]
					cls.op = OP_STRING_COPY;
				end else if ((opc & OPC_W_MSK) == OPC_STR_COMPARE) begin // [RULE_05]
					cls.op = OP_STRING_COMPARE;
				end else if ((opc & OPC_W_MSK) == OPC_STR_FETCH) begin // [RULE_06]
					cls.op = OP_STRING_FETCH;
				end else if ((opc & OPC_W_MSK) == OPC_STR_STORE) begin // [RULE_06]
					cls.op = OP_STRING_STORE;
				end else if ((opc & OPC_W_MSK) == OPC_STR_SEARCH) begin // [RULE_06]
					cls.op = OP_STRING_SEARCH;
				end else if ((opc & OPC_EXT_DEVICE_MSK) == OPC_EXT_DEVICE) begin // [RULE_22]
					cls = mk(OP_EXTERNAL_DEVICE_OPCODE, 1'b1, LEN_NONE);
				end
			end
		endcase
	end

endmodule : odl_classifier

/* File: odl_decoder.sv */
// Notes on behaviour
// RULE_01 - 110100vw with middle field 011 decodes as rotate right through carry.
// RULE_02 - 1111011w with middle field 000 is flag-only AND with immediate.
// RULE_03 - 1000010w plus addressing byte is flag-only AND, no write back.
// RULE_04 - 000010dw decodes inclusive OR, 001100dw exclusive OR, each with addressing byte.
// RULE_05 - Decode string copy and compare; 1111001z is a repeat prefix.
// RULE_06 - Decode string fetch, store and search; size bit picks byte or word.
// RULE_07 - Unconditional branches: near word displacement, short byte, far offset plus segment.
// RULE_08 - Subroutine exits near and far, each optionally with a stack immediate.
// RULE_09 - Signed branches less, less-equal, greater, each with one displacement byte.
// RULE_10 - Unsigned branches below, below-equal, above, each with one displacement byte.
// RULE_11 - Branches on equal, not-equal, overflow, each with one displacement byte.
// RULE_12 - Branches on parity even, parity odd, negative, each one displacement byte.
// RULE_13 - 11100010 with displacement is a counted branch on the count register.
// RULE_14 - 11100001 counts while zero, 11100000 while not zero; one displacement byte.
// RULE_15 - 11100011 branches only when the count register is zero.
// RULE_16 - Traps: typed with a type byte, fixed type 3, and on overflow.
// RULE_17 - 11001111 is the return from an interrupt service routine.
// RULE_18 - Carry clear, invert and set, each one byte.
// RULE_19 - Direction clear and set, each one byte.
// RULE_20 - Interrupt enable clear and set, each one byte.
// RULE_21 - One-byte bus lock prefix, processor stop and wait.
// RULE_22 - 11011xxx escapes; low opcode bits and middle field pass on raw.
// RULE_23 - Size bit set means word, clear means byte.
// RULE_24 - Addressing form 11 makes the operand selector a register.
// RULE_25 - Repeat prefix z bit is compared with zero flag to end compare/search.
// RULE_26 - Branch displacements are signed and added to the next instruction address.
`timescale 1ns/1ps
module odl_decoder
	import odl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic restart,
	input wire logic [15:0] restart_ip,
	input odl_byte_t byte_in,
	output logic byte_ready,
	input wire logic zero_flag,
	output logic dec_valid,
	input wire logic dec_ready,
	output odl_instr_t dec_out,
	output logic rep_finished
);

	odl_ctx_t ctx_r;
	odl_ctx_t ctx_nxt;
	odl_class_t cls;
	logic [7:0] cls_opc;
	logic [7:0] cls_modrm;
	logic [15:0] target;
	logic accepting;
	logic take;
	logic [1:0] mode;

	assign cls_opc = (ctx_r.st == ST_OPC) ? byte_in.data : ctx_r.opc;
	assign cls_modrm = (ctx_r.st == ST_MODRM) ? byte_in.data : ctx_r.modrm;
	assign mode = f_mod(ctx_r.modrm);

	odl_classifier u_classifier (
		.opc(cls_opc),
		.modrm(cls_modrm),
		.cls(cls)
	);

	odl_branch_target u_branch_target (
		.next_ip(ctx_r.ip),
		.disp_low(ctx_r.ibuf[0]),
		.disp_high(ctx_r.ibuf[1]),
		.short_form(cls.imm_len == LEN_BYTE),
		.target(target)
	);

	assign accepting = ctx_r.st inside {ST_OPC, ST_MODRM, ST_DISP, ST_IMM};
	assign byte_ready = clk_en & ~restart & accepting;
	assign take = byte_in.valid & accepting;
	assign dec_valid = ctx_r.st == ST_OUT;
	assign dec_out = ctx_r.out;

	// The execution unit samples this with its live zero flag while the instruction is shown.
	assign rep_finished = dec_valid & ctx_r.out.string_iteration_prefix & (zero_flag != ctx_r.out.rep_z) // [RULE_25]
		& (ctx_r.out.op inside {OP_STRING_COMPARE, OP_STRING_SEARCH});

	always_comb begin
		ctx_nxt = ctx_r;
		if (restart) begin
			ctx_nxt.st = ST_OPC;
			ctx_nxt.ip = restart_ip;
			ctx_nxt.string_iteration_prefix = 1'b0;
			ctx_nxt.rep_z = 1'b0;
			ctx_nxt.lock = 1'b0;
			ctx_nxt.len = '0;
		end else begin
			if (take) begin
				ctx_nxt.ip = ctx_r.ip + 16'h0001;
				ctx_nxt.len = ctx_r.len + INSTR_LEN_ONE;
			end
			unique case (ctx_r.st)
				ST_OPC: begin
					if (take) begin
						ctx_nxt.opc = byte_in.data;
						ctx_nxt.modrm = '0;
						ctx_nxt.dsp = '0;
						ctx_nxt.ibuf = '0;
						ctx_nxt.idx = '0;
						ctx_nxt.cnt = cls.imm_len;
						// Prefixes are held and attached to the next real opcode.
						if ((byte_in.data & OPC_W_MSK) == OPC_ITER) begin // [RULE_05]
							ctx_nxt.string_iteration_prefix = 1'b1;
							ctx_nxt.rep_z = byte_in.data[Z_BIT]; // [RULE_25]
						end else if (byte_in.data == OPC_BUS_LOCK) begin // [RULE_21]
							ctx_nxt.lock = 1'b1;
						end else if (cls.has_modrm) begin
							ctx_nxt.st = ST_MODRM;
						end else if (cls.imm_len != LEN_NONE) begin
							ctx_nxt.st = ST_IMM;
						end else begin
							ctx_nxt.st = ST_FIN;
						end
					end
				end
				ST_MODRM: begin
					if (take) begin
						ctx_nxt.modrm = byte_in.data;
						if (f_disp_len(byte_in.data) != LEN_NONE) begin
							ctx_nxt.st = ST_DISP;
							ctx_nxt.cnt = f_disp_len(byte_in.data);
						end else if (cls.imm_len != LEN_NONE) begin
							ctx_nxt.st = ST_IMM;
							ctx_nxt.cnt = cls.imm_len; // [RULE_02]
						end else begin
							ctx_nxt.st = ST_FIN;
						end
					end
				end
				ST_DISP: begin
					if (take) begin
						ctx_nxt.dsp[ctx_r.idx[0]] = byte_in.data;
						ctx_nxt.idx = ctx_r.idx + 2'h1;
						ctx_nxt.cnt = ctx_r.cnt - LEN_BYTE;
						if (ctx_r.cnt == LEN_BYTE) begin
							ctx_nxt.idx = '0;
							ctx_nxt.cnt = cls.imm_len;
							ctx_nxt.st = (cls.imm_len != LEN_NONE) ? ST_IMM : ST_FIN;
						end
					end
				end
				ST_IMM: begin
					if (take) begin
						ctx_nxt.ibuf[ctx_r.idx] = byte_in.data;
						ctx_nxt.idx = ctx_r.idx + 2'h1;
						ctx_nxt.cnt = ctx_r.cnt - LEN_BYTE;
						if (ctx_r.cnt == LEN_BYTE) begin
							ctx_nxt.st = ST_FIN;
						end
					end
				end
				ST_FIN: begin
					ctx_nxt.out.op = cls.op;
					ctx_nxt.out.opc = ctx_r.opc;
					ctx_nxt.out.modrm = ctx_r.modrm;
					ctx_nxt.out.word = ctx_r.opc[W_BIT]; // [RULE_23]
					ctx_nxt.out.dir = ctx_r.opc[D_BIT]; // [RULE_04]
					ctx_nxt.out.count_cl = ctx_r.opc[V_BIT]; // [RULE_01]
					ctx_nxt.out.rm_is_reg = cls.has_modrm && mode == MOD_REG; // [RULE_24]
					ctx_nxt.out.esc_code = {f_rm(ctx_r.opc), f_reg(ctx_r.modrm)}; // [RULE_22]
					ctx_nxt.out.mem_disp = (mode == MOD_DISP8) ?
						{{8{ctx_r.dsp[0][7]}}, ctx_r.dsp[0]} : {ctx_r.dsp[1], ctx_r.dsp[0]};
					ctx_nxt.out.imm = {ctx_r.ibuf[1], ctx_r.ibuf[0]}; // [RULE_08]
					ctx_nxt.out.seg = {ctx_r.ibuf[3], ctx_r.ibuf[2]}; // [RULE_07]
					ctx_nxt.out.next_ip = ctx_r.ip;
					ctx_nxt.out.target = target; // [RULE_26]
					ctx_nxt.out.string_iteration_prefix = ctx_r.string_iteration_prefix;
					ctx_nxt.out.rep_z = ctx_r.rep_z;
					ctx_nxt.out.lock = ctx_r.lock;
					ctx_nxt.out.len = ctx_r.len;
					ctx_nxt.st = ST_OUT;
				end
				ST_OUT: begin
					if (dec_ready) begin
						ctx_nxt.st = ST_OPC;
						ctx_nxt.string_iteration_prefix = 1'b0;
						ctx_nxt.rep_z = 1'b0;
						ctx_nxt.lock = 1'b0;
						ctx_nxt.len = '0;
					end
				end
				default: begin
					ctx_nxt.st = ST_OPC;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctx_r <= '0;
		end else if (clk_en) begin
			ctx_r <= ctx_nxt;
		end
	end

	property p_rotate_carry;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && ((dec_out.opc & OPC_SHIFT_MSK) == OPC_SHIFT)
			&& f_reg(dec_out.modrm) == REG_ROTATE_CARRY_RIGHT
			|-> dec_out.op == OP_ROTATE_RIGHT_THROUGH_CARRY;
	endproperty
	a_rotate_carry: assert property (p_rotate_carry) else $error("rotate decode wrong"); // [RULE_01]

	property p_and_imm_len;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_FLAG_AND_IMM && !dec_out.word |-> dec_out.imm[15:8] == 8'h00;
	endproperty
	a_and_imm_len: assert property (p_and_imm_len) else $error("byte immediate too long"); // [RULE_02]

	property p_reg_form;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_XOR_RM |-> dec_out.rm_is_reg == (f_mod(dec_out.modrm) == MOD_REG);
	endproperty
	a_reg_form: assert property (p_reg_form) else $error("register form flag wrong"); // [RULE_24]

	property p_short_target;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_BRANCH_IF_LESS
			|-> dec_out.target == dec_out.next_ip + {{8{dec_out.imm[7]}}, dec_out.imm[7:0]};
	endproperty
	a_short_target: assert property (p_short_target) else $error("short target wrong"); // [RULE_26]

	property p_far_len;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_BRANCH_FAR
			|-> dec_out.len - 4'(dec_out.string_iteration_prefix) - 4'(dec_out.lock) == INSTR_LEN_FAR;
	endproperty
	a_far_len: assert property (p_far_len) else $error("far branch length wrong"); // [RULE_07]

	property p_counted_len;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_BRANCH_IF_COUNTER_ZERO
			|-> dec_out.len - 4'(dec_out.string_iteration_prefix) - 4'(dec_out.lock) == INSTR_LEN_COND;
	endproperty
	a_counted_len: assert property (p_counted_len) else $error("counted branch length wrong"); // [RULE_15]

	property p_esc_fields;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_EXTERNAL_DEVICE_OPCODE
			|-> dec_out.esc_code == {dec_out.opc[2:0], dec_out.modrm[5:3]};
	endproperty
	a_esc_fields: assert property (p_esc_fields) else $error("escape code wrong"); // [RULE_22]

	property p_hold_out;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && !dec_ready && !restart |=> dec_valid && $stable(dec_out);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("decoded output dropped"); // [RULE_23]

	property p_carry_one_byte;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.op == OP_CARRY_INVERT
			|-> dec_out.len - 4'(dec_out.string_iteration_prefix) - 4'(dec_out.lock) == INSTR_LEN_ONE;
	endproperty
	a_carry_one_byte: assert property (p_carry_one_byte) else $error("carry op length wrong"); // [RULE_18]

	property p_rep_end;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid && dec_out.string_iteration_prefix && dec_out.op == OP_STRING_SEARCH
			|-> rep_finished == (zero_flag != dec_out.rep_z);
	endproperty
	a_rep_end: assert property (p_rep_end) else $error("repeat end wrong"); // [RULE_25]

	// These follow single opcodes, and the 1000010w pair for flag-only AND, through the classifier and the output register.
	property p_trap_exit;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid
			&& dec_out.opc == OPC_TRAP_EXIT
			|-> dec_out.op == OP_TRAP_EXIT;
	endproperty
	a_trap_exit: assert property (p_trap_exit) else $error("trap exit wrong"); // [RULE_17]

	property p_counted;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid
			&& dec_out.opc == OPC_COUNTED
			|-> dec_out.op == OP_COUNTED_BRANCH;
	endproperty
	a_counted: assert property (p_counted) else $error("counted loop wrong"); // [RULE_13]

	property p_flag_and_rm;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid
			&& (dec_out.opc & OPC_W_MSK) == OPC_FLAG_AND_RM
			|-> dec_out.op == OP_FLAG_AND_RM;
	endproperty
	a_flag_and_rm: assert property (p_flag_and_rm) else $error("flag and wrong"); // [RULE_03]

	property p_irq_set;
		@(posedge sys_clk) disable iff (!rst_n)
		dec_valid
			&& dec_out.opc == OPC_IRQ_ENABLE_SET
			|-> dec_out.op == OP_IRQ_ENABLE_SET;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq set decode wrong"); // [RULE_20]

endmodule : odl_decoder

/* File: odl_decoder_tb.sv */
`timescale 1ns/1ps
module odl_decoder_tb;
	import odl_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic restart = 1'b0;
	logic [15:0] restart_ip = 16'h0000;
	logic zero_flag = 1'b0;
	logic stall = 1'b0;
	logic clk_en = 1'b1;
	logic byte_ready;
	logic dec_valid;
	logic dec_ready;
	logic rep_finished;
	odl_byte_t byte_in;
	odl_instr_t dec_out;
	odl_instr_t got;
	logic [15:0] ip_e;
	int failures = 0;
	int checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	odl_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .restart(restart),
		.restart_ip(restart_ip), .byte_in(byte_in), .byte_ready(byte_ready),
		.zero_flag(zero_flag), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.dec_out(dec_out), .rep_finished(rep_finished));
	odl_partner prt (.sys_clk(sys_clk), .rst_n(rst_n), .byte_ready(byte_ready),
		.stall(stall), .byte_in(byte_in), .dec_ready(dec_ready));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic results();
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic send(input logic [7:0] b[$], input odl_op_t op);
		int n;
		n = 0;
		while (dec_valid !== 1'b0 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		foreach (b[i]) prt.q.push_back(b[i]);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (dec_valid !== 1'b1 && n < 50);
		got = dec_out;
		check("dec_valid", dec_valid, 1'b1);
		check("op", got.op, op);
		check("len", got.len, b.size());
		ip_e = ip_e + 16'(b.size());
		check("next_ip", got.next_ip, ip_e);
	endtask : send
	task automatic t_branch();
		@(posedge sys_clk) restart <= 1'b1;
		restart_ip <= 16'h0100;
		@(posedge sys_clk) restart <= 1'b0;
		ip_e = 16'h0100;
		send('{8'heb, 8'h05}, OP_BRANCH_SHORT);
		check("target", got.target, 16'h0107);
		send('{8'he9, 8'h00, 8'hf0}, OP_BRANCH_NEAR);
		check("target", got.target, 16'hf105);
		send('{8'hea, 8'h11, 8'h22, 8'h33, 8'h44}, OP_BRANCH_FAR);
		check("seg_imm", {got.seg, got.imm}, 32'h4433_2211);
		send('{8'hc2, 8'h10, 8'h00}, OP_EXIT_NEAR_IMM);
		check("imm", got.imm, 16'h0010);
		send('{8'hca, 8'h00, 8'h80}, OP_EXIT_FAR_IMM);
		check("imm", got.imm, 16'h8000);
		send('{8'hcd, 8'h21}, OP_TRAP_TYPE);
	endtask : t_branch
	task automatic t_single();
		logic [7:0] c[19] = '{8'hc3, 8'hcb, 8'hcc, 8'hce, 8'hcf, 8'hf8, 8'hf5, 8'hf9, 8'hfc,
			8'hfd, 8'hfa, 8'hfb, 8'hf4, 8'h9b, 8'ha4, 8'ha6, 8'hac, 8'haa, 8'haf};
		odl_op_t o[19] = '{OP_EXIT_NEAR, OP_EXIT_FAR, OP_TRAP_BREAK, OP_TRAP_OVERFLOW,
			OP_TRAP_EXIT, OP_CARRY_CLEAR, OP_CARRY_INVERT, OP_CARRY_SET, OP_DIRECTION_CLEAR,
			OP_DIRECTION_SET, OP_IRQ_ENABLE_CLEAR, OP_IRQ_ENABLE_SET, OP_PROCESSOR_STOP,
			OP_COPROC_WAIT, OP_STRING_COPY, OP_STRING_COMPARE, OP_STRING_FETCH,
			OP_STRING_STORE, OP_STRING_SEARCH};
		foreach (c[i]) begin
			send('{c[i]}, o[i]); // to
			check("word", got.word, c[i][0]);
		end
	endtask : t_single
	task automatic t_cond();
		logic [15:0] t;
		logic [7:0] c[16] = '{8'h7c, 8'h7e, 8'h7f, 8'h72, 8'h76, 8'h77, 8'h74, 8'h75, 8'h70,
			8'h7a, 8'h7b, 8'h78, 8'he2, 8'he1, 8'he0, 8'he3};
		odl_op_t o[16] = '{OP_BRANCH_IF_LESS, OP_BRANCH_IF_LESS_EQUAL, OP_BRANCH_IF_GREATER,
			OP_BRANCH_IF_BELOW, OP_BRANCH_IF_BELOW_EQUAL, OP_BRANCH_IF_ABOVE,
			OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_OVERFLOW,
			OP_BRANCH_IF_PARITY_EVEN, OP_BRANCH_IF_PARITY_ODD, OP_BRANCH_IF_NEGATIVE,
			OP_COUNTED_BRANCH, OP_COUNTED_BRANCH_WHILE_ZERO,
			OP_COUNTED_BRANCH_WHILE_NONZERO, OP_BRANCH_IF_COUNTER_ZERO};
		foreach (c[i]) begin
			t = ip_e - 16'h007e;
			send('{c[i], 8'h80}, o[i]); // to
			check("target", got.target, t);
		end
	endtask : t_cond
	task automatic t_modrm();
		send('{8'hd0, 8'hd8}, OP_ROTATE_RIGHT_THROUGH_CARRY);
		check("reg_word", {got.count_cl, got.rm_is_reg, got.word}, 3'b010);
		send('{8'hd3, 8'h1e, 8'h34, 8'h12}, OP_ROTATE_RIGHT_THROUGH_CARRY);
		check("disp", {got.count_cl, got.rm_is_reg, got.word, got.mem_disp}, 19'h5_1234);
		send('{8'hf7, 8'hc0, 8'h34, 8'h12}, OP_FLAG_AND_IMM);
		check("imm", got.imm, 16'h1234);
		send('{8'hf6, 8'hc0, 8'h56}, OP_FLAG_AND_IMM);
		check("imm", got.imm[7:0], 8'h56);
		send('{8'h85, 8'hc1}, OP_FLAG_AND_RM);
		send('{8'h0a, 8'hc1}, OP_OR_RM);
		check("dir", got.dir, 1'b1);
		send('{8'h31, 8'hc1}, OP_XOR_RM);
		check("dir", got.dir, 1'b0);
		send('{8'hdd, 8'h7a, 8'h80}, OP_EXTERNAL_DEVICE_OPCODE);
		check("esc", {got.esc_code, got.mem_disp}, 22'h2f_ff80);
	endtask : t_modrm
	task automatic t_rep();
		@(posedge sys_clk) stall <= 1'b1;
		zero_flag <= 1'b1;
		send('{8'hf3, 8'ha6}, OP_STRING_COMPARE);
		check("rep", {got.string_iteration_prefix, got.rep_z, rep_finished}, 3'b110);
		@(posedge sys_clk) zero_flag <= 1'b0;
		@(negedge sys_clk) check("rep_finished", rep_finished, 1'b1);
		@(posedge sys_clk) clk_en <= 1'b0;
		stall <= 1'b0;
		repeat (3) @(negedge sys_clk);
		check("frozen", {dec_valid, rep_finished}, 2'b11);
		@(posedge sys_clk) clk_en <= 1'b1;
		send('{8'hf0, 8'hf4}, OP_PROCESSOR_STOP);
		check("lock", got.lock, 1'b1);
	endtask : t_rep
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_branch();
		t_single();
		t_cond();
		t_modrm();
		t_rep();
		results();
	end
	initial begin
		#200000;
		failures++;
		results();
	end
endmodule : odl_decoder_tb

/* File: odl_partner.sv */
`timescale 1ns/1ps
module odl_partner
	import odl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic byte_ready,
	input wire logic stall,
	output odl_byte_t byte_in,
	output logic dec_ready
);
	logic [7:0] q[$];
	// An idle byte lane flips every cycle so a stale byte never looks valid.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_in <= '0;
			dec_ready <= 1'b0;
		end else begin
			if (byte_in.valid && byte_ready) begin
				void'(q.pop_front());
			end
			if (q.size() != 0) begin
				byte_in <= {1'b1, q[0]};
			end else begin
				byte_in <= {1'b0, ~byte_in.data};
			end
			dec_ready <= !stall;
		end
	end
endmodule : odl_partner

/* File: odl_pkg.sv */
package odl_pkg;

	localparam logic [7:0] OPC_SHIFT = 8'hd0;
	localparam logic [7:0] OPC_SHIFT_MSK = 8'hfc;
	localparam logic [2:0] REG_ROTATE_CARRY_RIGHT = 3'h3;
	localparam logic [7:0] OPC_FLAG_AND_IMM = 8'hf6;
	localparam logic [2:0] REG_FLAG_AND_IMM = 3'h0;
	localparam logic [7:0] OPC_FLAG_AND_RM = 8'h84;
	localparam logic [7:0] OPC_OR_RM = 8'h08;
	localparam logic [7:0] OPC_XOR_RM = 8'h30;
	localparam logic [7:0] OPC_DW_MSK = 8'hfc;
	localparam logic [7:0] OPC_W_MSK = 8'hfe;
	localparam logic [7:0] OPC_ITER = 8'hf2;
	localparam logic [7:0] OPC_STR_COPY = 8'ha4;
	localparam logic [7:0] OPC_STR_COMPARE = 8'ha6;
	localparam logic [7:0] OPC_STR_FETCH = 8'hac;
	localparam logic [7:0] OPC_STR_STORE = 8'haa;
	localparam logic [7:0] OPC_STR_SEARCH = 8'hae;
	localparam logic [7:0] OPC_BR_NEAR = 8'he9;
	localparam logic [7:0] OPC_BR_SHORT = 8'heb;
	localparam logic [7:0] OPC_BR_FAR = 8'hea;
	localparam logic [7:0] OPC_EXIT_NEAR = 8'hc3;
	localparam logic [7:0] OPC_EXIT_NEAR_IMM = 8'hc2;
	localparam logic [7:0] OPC_EXIT_FAR = 8'hcb;
	localparam logic [7:0] OPC_EXIT_FAR_IMM = 8'hca;
	localparam logic [7:0] OPC_BR_LESS = 8'h7c;
	localparam logic [7:0] OPC_BR_LESS_EQUAL = 8'h7e;
	localparam logic [7:0] OPC_BR_GREATER = 8'h7f;
	localparam logic [7:0] OPC_BR_BELOW = 8'h72;
	localparam logic [7:0] OPC_BR_BELOW_EQUAL = 8'h76;
	localparam logic [7:0] OPC_BR_ABOVE = 8'h77;
	localparam logic [7:0] OPC_BR_EQUAL = 8'h74;
	localparam logic [7:0] OPC_BR_NOT_EQUAL = 8'h75;
	localparam logic [7:0] OPC_BR_OVERFLOW = 8'h70;
	localparam logic [7:0] OPC_BR_PARITY_EVEN = 8'h7a;
	localparam logic [7:0] OPC_BR_PARITY_ODD = 8'h7b;
	localparam logic [7:0] OPC_BR_NEGATIVE = 8'h78;
	localparam logic [7:0] OPC_COUNTED = 8'he2;
	localparam logic [7:0] OPC_COUNTED_ZERO = 8'he1;
	localparam logic [7:0] OPC_COUNTED_NONZERO = 8'he0;
	localparam logic [7:0] OPC_BR_COUNTER_ZERO = 8'he3;
	localparam logic [7:0] OPC_TRAP_TYPE = 8'hcd;
	localparam logic [7:0] OPC_TRAP_BREAK = 8'hcc;
	localparam logic [7:0] OPC_TRAP_OVERFLOW = 8'hce;
	localparam logic [7:0] OPC_TRAP_EXIT = 8'hcf;
	localparam logic [7:0] OPC_CARRY_CLEAR = 8'hf8;
	localparam logic [7:0] OPC_CARRY_INVERT = 8'hf5;
	localparam logic [7:0] OPC_CARRY_SET = 8'hf9;
	localparam logic [7:0] OPC_DIRECTION_CLEAR = 8'hfc;
	localparam logic [7:0] OPC_DIRECTION_SET = 8'hfd;
	localparam logic [7:0] OPC_IRQ_ENABLE_CLEAR = 8'hfa;
	localparam logic [7:0] OPC_IRQ_ENABLE_SET = 8'hfb;
	localparam logic [7:0] OPC_BUS_LOCK = 8'hf0;
	localparam logic [7:0] OPC_PROCESSOR_STOP = 8'hf4;
	localparam logic [7:0] OPC_COPROC_WAIT = 8'h9b;
	localparam logic [7:0] OPC_EXT_DEVICE = 8'hd8;
	localparam logic [7:0] OPC_EXT_DEVICE_MSK = 8'hf8;

	localparam int W_BIT = 0;
	localparam int D_BIT = 1;
	localparam int V_BIT = 1;
	localparam int Z_BIT = 0;
	localparam logic [1:0] MOD_MEM = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;

	localparam logic [2:0] LEN_NONE = 3'h0;
	localparam logic [2:0] LEN_BYTE = 3'h1;
	localparam logic [2:0] LEN_WORD = 3'h2;
	localparam logic [2:0] LEN_FAR = 3'h4;
	localparam logic [3:0] INSTR_LEN_ONE = 4'h1;
	localparam logic [3:0] INSTR_LEN_COND = 4'h2;
	localparam logic [3:0] INSTR_LEN_FAR = 4'h5;

	typedef enum logic [5:0] {
		OP_NONE, OP_ROTATE_RIGHT_THROUGH_CARRY, OP_FLAG_AND_RM, OP_FLAG_AND_IMM,
		OP_OR_RM, OP_XOR_RM, OP_STRING_COPY, OP_STRING_COMPARE, OP_STRING_FETCH,
		OP_STRING_STORE, OP_STRING_SEARCH, OP_BRANCH_NEAR, OP_BRANCH_SHORT,
		OP_BRANCH_FAR, OP_EXIT_NEAR, OP_EXIT_NEAR_IMM, OP_EXIT_FAR, OP_EXIT_FAR_IMM,
		OP_BRANCH_IF_LESS, OP_BRANCH_IF_LESS_EQUAL, OP_BRANCH_IF_GREATER,
		OP_BRANCH_IF_BELOW, OP_BRANCH_IF_BELOW_EQUAL, OP_BRANCH_IF_ABOVE,
		OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_OVERFLOW,
		OP_BRANCH_IF_PARITY_EVEN, OP_BRANCH_IF_PARITY_ODD, OP_BRANCH_IF_NEGATIVE,
		OP_COUNTED_BRANCH, OP_COUNTED_BRANCH_WHILE_ZERO, OP_COUNTED_BRANCH_WHILE_NONZERO,
		OP_BRANCH_IF_COUNTER_ZERO, OP_TRAP_TYPE, OP_TRAP_BREAK, OP_TRAP_OVERFLOW,
		OP_TRAP_EXIT, OP_CARRY_CLEAR, OP_CARRY_INVERT, OP_CARRY_SET,
		OP_DIRECTION_CLEAR, OP_DIRECTION_SET, OP_IRQ_ENABLE_CLEAR, OP_IRQ_ENABLE_SET,
		OP_PROCESSOR_STOP, OP_COPROC_WAIT, OP_EXTERNAL_DEVICE_OPCODE
	} odl_op_t;

	typedef enum logic [2:0] {
		ST_OPC = 3'h0,
		ST_MODRM = 3'h1,
		ST_DISP = 3'h3,
		ST_IMM = 3'h2,
		ST_FIN = 3'h6,
		ST_OUT = 3'h7
	} odl_state_t;

	typedef struct packed {
		odl_op_t op;
		logic has_modrm;
		logic [2:0] imm_len;
	} odl_class_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} odl_byte_t;

	typedef struct packed {
		odl_op_t op;
		logic [7:0] opc;
		logic [7:0] modrm;
		logic word;
		logic dir;
		logic count_cl;
		logic rm_is_reg;
		logic [5:0] esc_code;
		logic [15:0] mem_disp;
		logic [15:0] imm;
		logic [15:0] seg;
		logic [15:0] next_ip;
		logic [15:0] target;
		logic string_iteration_prefix;
		logic rep_z;
		logic lock;
		logic [3:0] len;
	} odl_instr_t;

	typedef struct packed {
		odl_state_t st;
		logic [7:0] opc;
		logic [7:0] modrm;
		logic [2:0] cnt;
		logic [1:0] idx;
		logic [1:0][7:0] dsp;
		logic [3:0][7:0] ibuf;
		logic [15:0] ip;
		logic string_iteration_prefix;
		logic rep_z;
		logic lock;
		logic [3:0] len;
		odl_instr_t out;
	} odl_ctx_t;

	function automatic logic [1:0] f_mod(input logic [7:0] m);
		return m[7:6];
	endfunction : f_mod

	function automatic logic [2:0] f_reg(input logic [7:0] m);
		return m[5:3];
	endfunction : f_reg

	function automatic logic [2:0] f_rm(input logic [7:0] m);
		return m[2:0];
	endfunction : f_rm

	function automatic logic [2:0] f_disp_len(input logic [7:0] m);
		if (f_mod(m) == MOD_DISP8) begin
			return LEN_BYTE;
		end
		if (f_mod(m) == MOD_DISP16 || (f_mod(m) == MOD_MEM && f_rm(m) == RM_DIRECT)) begin
			return LEN_WORD;
		end
		return LEN_NONE;
	endfunction : f_disp_len

endpackage : odl_pkg
